/* design/tocs_top.sv */
// Overview of operation
// R1 - The output control register takes writes per byte lane and reads as a whole word, so words, bytes and bits work.
// R2 - Any reset loads the output control register with 4444 hex, active levels high and all else clear.
// R3 - An output-enable bit at zero holds its channel pin at the inactive level, at one lets the timer drive it.
// R4 - An active-level bit at zero makes its channel pin active low, at one active high.
// R5 - Software stops the counter and waits for its running flag to read zero before changing an active level.
// R6 - Software does not rewrite an active level while power and the matching counter enable are both set.
// R7 - In capture mode an input edge copies the assigned counter into the channel register and raises its event.
// R8 - In compare mode equality of register and assigned counter raises the event, and the pin runs PWM if enabled.
// R9 - Software changes capture/compare mode bits only while the power bit is zero.
// R10 - The timebase status register is read-only.
// R11 - Any reset clears the timebase status register.
// R12 - Status bits 5 to 0 show whether the assigned counter overflowed between two captures of each register.
// R13 - An overflow status bit updates only when its capture/compare register is read, so that is read first.
// R14 - Status bits 7 and 6 show that the second and first counters are running.
// R15 - Clearing a counter enable stops and deactivates it after one clock, setting it starts after four.
// R16 - Each pin channel follows the first counter when its assignment bit is zero and the second when one.
// R17 - A pin held inactive drives the complement of its active level, and unused bits read as zero.
`timescale 1ns/1ns
module tocs_top
    import tocs_pkg::*;
(
    input  wire logic                        mclk_in,
    input  wire logic                        rst_n_in,
    input  wire logic [tocs_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [tocs_pkg::DATA_W-1:0] pwdata_in,
    input  wire logic [3:0]                  pstrb_in,
    output logic [tocs_pkg::DATA_W-1:0]      prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    input  wire logic [tocs_pkg::CNT_W-1:0]  counter0_in,
    input  wire logic [tocs_pkg::CNT_W-1:0]  counter1_in,
    input  wire logic [tocs_pkg::NCNT-1:0]   counter_ovf_in,
    input  wire logic [tocs_pkg::NCHAN-1:0]  capture_edge_in,
    output logic [tocs_pkg::NCNT-1:0]        counter_run_out,
    output logic [tocs_pkg::NCNT-1:0]        counter_clear_out,
    output logic [tocs_pkg::NPIN-1:0]        channel_output_pin_out,
    output logic [tocs_pkg::NCHAN-1:0]       channel_match_interrupt_out,
    output logic                             irq_out
);
    import tocs_pkg::*;

    logic [15:0]       mode_q;
    logic [15:0]       mode_d;
    logic [15:0]       chmode_q;
    logic [15:0]       chmode_d;
    logic [15:0]       outctl_q;
    logic [15:0]       outctl_d;
    logic [NCHAN-1:0]  istat_q;
    logic [NCHAN-1:0]  istat_d;
    logic [NCHAN-1:0]  imask_q;
    logic [NCHAN-1:0]  imask_d;
    logic              irq_q;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] rdata;

    wire  logic              setup;
    wire  logic              wr_acc;
    wire  logic              rd_acc;
    wire  logic              hit_mode;
    wire  logic              hit_chmode;
    wire  logic              hit_outctl;
    wire  logic              hit_tbstat;
    wire  logic              hit_istat;
    wire  logic              hit_imask;
    wire  logic [NCHAN-1:0]  hit_cc;
    wire  logic              mapped;
    wire  logic [NCNT-1:0]   cnt_en;
    wire  logic [NCNT-1:0]   running;
    wire  logic [NCHAN-1:0]  events;
    wire  logic [NCHAN-1:0]  ovf_flags;
    wire  logic [NCHAN-1:0]  pins;
    wire  logic [7:0]        tbstat;
    wire  logic [15:0]       wdata16;
    wire  logic [1:0]        wstrb16;
    wire  logic [CNT_W-1:0]  ccr     [NCHAN];
    wire  logic [CNT_W-1:0]  cc_rd   [NCHAN];
    tocs_chcfg_t             cfg     [NCHAN];

    // Bus decode
    assign setup      = psel_in && !penable_in;
    assign wr_acc     = psel_in && penable_in && pwrite_in;
    assign rd_acc     = psel_in && penable_in && !pwrite_in;
    assign hit_mode   = (paddr_in == ADDR_MODE);
    assign hit_chmode = (paddr_in == ADDR_CHMODE);
    assign hit_outctl = (paddr_in == ADDR_OUTCTL);
    assign hit_tbstat = (paddr_in == ADDR_TBSTAT);
    assign hit_istat  = (paddr_in == ADDR_IRQSTAT);
    assign hit_imask  = (paddr_in == ADDR_IRQMASK);
    assign mapped     = hit_mode || hit_chmode || hit_outctl || hit_tbstat ||
                        hit_istat || hit_imask || (|hit_cc);
    assign wdata16    = pwdata_in[15:0];
    assign wstrb16    = pstrb_in[1:0];

    // Zero wait states; an unmapped address answers with an error and no effect
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // Register writes; only the two low byte lanes carry register bits
    assign mode_d   = (wr_acc && hit_mode) ?
                      tocs_merge16(mode_q, wdata16, wstrb16, MODE_WMASK) : mode_q;
    assign chmode_d = (wr_acc && hit_chmode) ?
                      tocs_merge16(chmode_q, wdata16, wstrb16, CHM_WMASK) : chmode_q;
    assign outctl_d = (wr_acc && hit_outctl) ?
                      tocs_merge16(outctl_q, wdata16, wstrb16, OC_WMASK) : outctl_q; // R1 R17
    assign imask_d  = (wr_acc && hit_imask && pstrb_in[0]) ? pwdata_in[NCHAN-1:0] : imask_q;

    // Clear only the bits the read returned; an event after the setup edge survives, set wins
    assign istat_d  = (istat_q & ~(prdata_q[NCHAN-1:0] & {NCHAN{rd_acc && hit_istat}})) | events;

    // Counters run only with power and their own enable both set
    assign cnt_en[0] = mode_q[MODE_POWER] && mode_q[MODE_CNT0_EN]; // R15
    assign cnt_en[1] = mode_q[MODE_POWER] && mode_q[MODE_CNT1_EN]; // R15

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mode_q   <= MODE_RESET;
            chmode_q <= CHM_RESET;
            outctl_q <= OC_RESET; // R2
            istat_q  <= '0;
            imask_q  <= '0;
            irq_q    <= 1'b0;
        end
        else
        begin
            mode_q   <= mode_d;
            chmode_q <= chmode_d;
            outctl_q <= outctl_d;
            istat_q  <= istat_d;
            imask_q  <= imask_d;
            irq_q    <= |(istat_d & imask_d);
        end
    end

    // Read data is taken in the setup cycle so the access phase shows a flop
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prdata_q <= '0;
        end
        else if (setup && !pwrite_in)
        begin
            prdata_q <= rdata;
        end
    end

    genvar gc;
    for (gc = 0; gc < NCNT; gc++)
    begin : g_run
        tocs_run #(
            .START (START_CLKS)
        ) u_run (
            .mclk_in  (mclk_in),
            .rst_n_in (rst_n_in),
            .en_in    (cnt_en[gc]),
            .run_out  (running[gc])
        ); // R15
    end

    genvar gi;
    for (gi = 0; gi < NCHAN; gi++)
    begin : g_chan
        wire logic sel;
        wire logic oe;
        wire logic alv;
        wire logic cmode;
        // Channels 0 and 5 belong to one counter each and have no pin
        if (gi == 0 || gi == NCHAN - 1)
        begin : g_fixed
            assign sel   = (gi == NCHAN - 1);
            assign oe    = 1'b0;
            assign alv   = 1'b0;
            assign cmode = 1'b0;
        end
        else
        begin : g_pin
            assign sel   = chmode_q[CHM_SEL_LSB + gi - 1]; // R16
            assign oe    = outctl_q[OC_FIELD_W * (gi - 1) + OC_OE_OFS]; // R3
            assign alv   = outctl_q[OC_FIELD_W * (gi - 1) + OC_ALV_OFS]; // R4
            assign cmode = outctl_q[OC_FIELD_W * (gi - 1) + OC_MODE_OFS];
        end
        assign cfg[gi]    = '{oe: oe, alv: alv, mode: cmode, sel: sel};
        assign hit_cc[gi] = (paddr_in == 8'(ADDR_CC0 + gi * ADDR_CC_STEP));
        assign cc_rd[gi]  = hit_cc[gi] ? ccr[gi] : '0;

        tocs_chan #(
            .CW (CNT_W)
        ) u_chan (
            .mclk_in      (mclk_in),
            .rst_n_in     (rst_n_in),
            .cfg_in       (cfg[gi]),
            .cnt_in       (sel ? counter1_in : counter0_in), // R16
            .ovf_in       (sel ? counter_ovf_in[1] : counter_ovf_in[0]),
            .run_in       (sel ? running[1] : running[0]),
            .edge_in      (capture_edge_in[gi]),
            .wr_in        (wr_acc && hit_cc[gi]),
            .wdata_in     (wdata16),
            .wstrb_in     (wstrb16),
            .rd_in        (rd_acc && hit_cc[gi]), // R13
            .ccr_out      (ccr[gi]),
            .event_out    (events[gi]),
            .ovf_flag_out (ovf_flags[gi]),
            .pin_out      (pins[gi])
        );
    end

    // Read selection
    logic [CNT_W-1:0] cc_sel;
    always_comb
    begin
        cc_sel = '0;
        for (int i = 0; i < NCHAN; i++)
        begin
            cc_sel = cc_sel | cc_rd[i];
        end
    end

    assign tbstat = {running[1], running[0], ovf_flags}; // R10 R11 R12 R14

    assign rdata = hit_mode   ? {16'h0000, mode_q}   :
                   hit_chmode ? {16'h0000, chmode_q} :
                   hit_outctl ? {16'h0000, outctl_q} : // R1
                   hit_tbstat ? {24'h000000, tbstat} : // R10
                   hit_istat  ? {26'h0000000, istat_q} :
                   hit_imask  ? {26'h0000000, imask_q} :
                   {16'h0000, cc_sel}; // R17

    assign prdata_out                  = prdata_q;
    assign counter_run_out             = running;
    assign counter_clear_out           = {events[NCHAN-1] && outctl_q[0], events[0] && outctl_q[0]};
    assign channel_output_pin_out      = pins[NPIN:1];
    assign channel_match_interrupt_out = events;
    assign irq_out                     = irq_q;

endmodule : tocs_top

/* common/tocs_pkg.sv */
package tocs_pkg;

    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          CNT_W       = 16;
    localparam int          NCHAN       = 6;
    localparam int          NPIN        = 4;
    localparam int          NCNT        = 2;

    // Register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_MODE    = 8'h00;
    localparam logic [7:0]  IDX_CHMODE  = 8'h02;
    localparam logic [7:0]  IDX_OUTCTL  = 8'h04;
    localparam logic [7:0]  IDX_TBSTAT  = 8'h06;
    localparam logic [7:0]  IDX_CC0     = 8'h0C;
    localparam logic [7:0]  IDX_CC_STEP = 8'h02;
    localparam logic [7:0]  IDX_IRQSTAT = 8'h20;
    localparam logic [7:0]  IDX_IRQMASK = 8'h22;

    localparam logic [ADDR_W-1:0] ADDR_MODE    = 8'(IDX_MODE * 4);
    localparam logic [ADDR_W-1:0] ADDR_CHMODE  = 8'(IDX_CHMODE * 4);
    localparam logic [ADDR_W-1:0] ADDR_OUTCTL  = 8'(IDX_OUTCTL * 4);
    localparam logic [ADDR_W-1:0] ADDR_TBSTAT  = 8'(IDX_TBSTAT * 4);
    localparam logic [ADDR_W-1:0] ADDR_CC0     = 8'(IDX_CC0 * 4);
    localparam logic [ADDR_W-1:0] ADDR_CC_STEP = 8'(IDX_CC_STEP * 4);
    localparam logic [ADDR_W-1:0] ADDR_IRQSTAT = 8'(IDX_IRQSTAT * 4);
    localparam logic [ADDR_W-1:0] ADDR_IRQMASK = 8'(IDX_IRQMASK * 4);

    // Timer mode register fields
    localparam int          MODE_CNT0_EN = 0;
    localparam int          MODE_CNT1_EN = 2;
    localparam int          MODE_POWER   = 15;
    localparam logic [15:0] MODE_WMASK   = 16'h8005;
    localparam logic [15:0] MODE_RESET   = 16'h0000;

    // Channel mode register: counter assignment bits of pin channels 1..4
    localparam int          CHM_SEL_LSB  = 12;
    localparam logic [15:0] CHM_WMASK    = 16'hF000;
    localparam logic [15:0] CHM_RESET    = 16'h0000;

    // Output control: one nibble per pin channel m, nibble m-1
    localparam int          OC_FIELD_W   = 4;
    localparam int          OC_MODE_OFS  = 1;
    localparam int          OC_ALV_OFS   = 2;
    localparam int          OC_OE_OFS    = 3;
    localparam logic [15:0] OC_WMASK     = 16'hEEEE;
    localparam logic [15:0] OC_RESET     = 16'h4444;

    // Timebase status fields
    localparam int          TB_OVF_LSB   = 0;
    localparam int          TB_RUN_LSB   = 6;
    localparam logic [7:0]  TB_RESET     = 8'h00;

    // Counter start and stop latency in peripheral clocks
    localparam int          START_CLKS   = 4;
    localparam int          STOP_CLKS    = 1;

    typedef struct packed {
        logic oe;
        logic alv;
        logic mode;
        logic sel;
    } tocs_chcfg_t;

    function automatic logic [15:0] tocs_merge16(input logic [15:0] old_v,
                                                 input logic [15:0] new_v,
                                                 input logic [1:0]  strb,
                                                 input logic [15:0] wmask);
        logic [15:0] m;
        m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_v & ~m) | (new_v & m);
    endfunction : tocs_merge16

endpackage : tocs_pkg

/* design/tocs_run.sv */
`timescale 1ns/1ns
module tocs_run
    import tocs_pkg::*;
#(
    parameter int START = START_CLKS
)(
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    input  wire logic en_in,
    output logic      run_out
);
    import tocs_pkg::*;

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       run_q;
    logic       run_d;

    // Stop takes effect on the first edge after the enable falls
    assign cnt_d = (!en_in || run_q) ? 3'h0 : 3'(cnt_q + 3'h1);
    assign run_d = en_in && (run_q || (cnt_q == 3'(START - 1)));

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q <= 3'h0;
            run_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end

    assign run_out = run_q;

endmodule : tocs_run

/* design/tocs_chan.sv */
`timescale 1ns/1ns
module tocs_chan
    import tocs_pkg::*;
#(
    parameter int CW = CNT_W
)(
    input  wire logic          mclk_in,
    input  wire logic          rst_n_in,
    input  tocs_pkg::tocs_chcfg_t cfg_in,
    input  wire logic [CW-1:0] cnt_in,
    input  wire logic          ovf_in,
    input  wire logic          run_in,
    input  wire logic          edge_in,
    input  wire logic          wr_in,
    input  wire logic [15:0]   wdata_in,
    input  wire logic [1:0]    wstrb_in,
    input  wire logic          rd_in,
    output logic [CW-1:0]      ccr_out,
    output logic               event_out,
    output logic               ovf_flag_out,
    output logic               pin_out
);
    import tocs_pkg::*;

    logic [CW-1:0] ccr_q;
    logic [CW-1:0] ccr_d;
    logic          pend_q;
    logic          pend_d;
    logic          capovf_q;
    logic          capovf_d;
    logic          flag_q;
    logic          flag_d;
    logic          event_q;
    logic          pin_q;
    logic          pin_d;
    wire  logic    capture;
    wire  logic    match;
    wire  logic    pwm_on;

    assign capture  = !cfg_in.mode && run_in && edge_in; // R7
    assign match    = cfg_in.mode && run_in && (cnt_in == ccr_q); // R8
    assign ccr_d    = capture ? cnt_in : // R7
                      (wr_in && cfg_in.mode) ? CW'(tocs_merge16(16'(ccr_q), wdata_in, wstrb_in, 16'hFFFF)) : ccr_q;
    // An overflow in the capture cycle still belongs to the interval just closed
    assign pend_d   = capture ? 1'b0 : (pend_q || ovf_in); // R12
    assign capovf_d = capture ? (pend_q || ovf_in) : capovf_q; // R12
    assign flag_d   = rd_in ? capovf_q : flag_q; // R13
    // Active while the counter is below the compare value
    assign pwm_on   = cfg_in.oe && run_in && cfg_in.mode && (cnt_in < ccr_q); // R3 R8 R15
    assign pin_d    = pwm_on ? cfg_in.alv : !cfg_in.alv; // R4 R17

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ccr_q    <= '0;
            pend_q   <= 1'b0;
            capovf_q <= 1'b0;
            flag_q   <= 1'b0;
            event_q  <= 1'b0;
            pin_q    <= 1'b0;
        end
        else
        begin
            ccr_q    <= ccr_d;
            pend_q   <= pend_d;
            capovf_q <= capovf_d;
            flag_q   <= flag_d;
            event_q  <= capture || match;
            pin_q    <= pin_d;
        end
    end

    assign ccr_out      = ccr_q;
    assign event_out    = event_q;
    assign ovf_flag_out = flag_q;
    assign pin_out      = pin_q;

endmodule : tocs_chan

/* testbench/tocs_top_assertions.sv */
`timescale 1ns/1ns
module tocs_top_assertions
    import tocs_pkg::*;
(
    input  wire logic                        mclk_in,
    input  wire logic                        rst_n_in,
    input  wire logic [tocs_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [tocs_pkg::DATA_W-1:0] pwdata_in,
    input  wire logic [3:0]                  pstrb_in,
    input  wire logic [tocs_pkg::DATA_W-1:0] prdata_out,
    input  wire logic                        pready_out,
    input  wire logic                        pslverr_out,
    input  wire logic [tocs_pkg::NCHAN-1:0]  capture_edge_in,
    input  wire logic [tocs_pkg::NCNT-1:0]   counter_run_out,
    input  wire logic [tocs_pkg::NPIN-1:0]   channel_output_pin_out,
    input  wire logic [tocs_pkg::NCHAN-1:0]  channel_match_interrupt_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // Shadow copies of the two registers whose contents shape the outputs
    logic [15:0] oc_q;
    logic [15:0] md_q;
    wire         acc    = psel_in & penable_in;
    wire         rd_acc = acc & !pwrite_in;
    wire  [15:0] lane   = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    wire         en0    = md_q[MODE_POWER] & md_q[MODE_CNT0_EN];
    wire         en1    = md_q[MODE_POWER] & md_q[MODE_CNT1_EN];
    wire  [3:0]  hold   = ~{oc_q[15], oc_q[11], oc_q[7], oc_q[3]};
    wire  [3:0]  inact  = ~{oc_q[14], oc_q[10], oc_q[6], oc_q[2]};
    wire         mapped = (paddr_in[2:0] == 3'h0) && ((paddr_in <= 8'h18) || (paddr_in >= 8'h30 && paddr_in <= 8'h58)
                          || paddr_in == 8'h80 || paddr_in == 8'h88);

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            oc_q <= OC_RESET;
            md_q <= MODE_RESET;
        end
        else if (acc && pwrite_in)
        begin
            if (paddr_in == ADDR_OUTCTL)
                oc_q <= (oc_q & ~(lane & OC_WMASK)) | (pwdata_in[15:0] & lane & OC_WMASK);
            if (paddr_in == ADDR_MODE)
                md_q <= (md_q & ~(lane & MODE_WMASK)) | (pwdata_in[15:0] & lane & MODE_WMASK);
        end
    end

    // Stopped for four edges after the enable lands, then running
    sequence s_start(logic r);
        !r [*4] ##1 r;
    endsequence

    chk_ready_always: assert property (psel_in |-> pready_out)
        else $error("pready low during a transfer");
    chk_err_unmapped: assert property (acc |-> pslverr_out == !mapped)
        else $error("pslverr does not match the address map");
    chk_run0_start: assert property ($rose(en0) && !counter_run_out[0] |-> s_start(counter_run_out[0]))
        else $error("counter0 start latency wrong");
    chk_run1_start: assert property ($rose(en1) && !counter_run_out[1] |-> s_start(counter_run_out[1]))
        else $error("counter1 start latency wrong");
    chk_run_stop: assert property ($fell(en0) |=> !counter_run_out[0])
        else $error("counter0 did not stop one clock after enable fell");
    chk_stat_running: assert property (rd_acc && paddr_in == ADDR_TBSTAT
        |-> prdata_out[7:6] == $past(counter_run_out) && prdata_out[31:8] == 24'h000000)
        else $error("status running bits wrong");
    chk_cap_event: assert property (channel_match_interrupt_out[5] == $past(capture_edge_in[5] & counter_run_out[1]))
        else $error("channel 5 capture event wrong");
    chk_pin_hold: assert property ((($past(hold) & (channel_output_pin_out ^ $past(inact)))) == 4'h0)
        else $error("disabled pin not at inactive level");
    chk_oc_unused: assert property (rd_acc && paddr_in == ADDR_OUTCTL |-> (prdata_out & 32'hFFFF_1111) == 32'h0)
        else $error("unused output control bits read nonzero");
endmodule : tocs_top_assertions

bind tocs_top tocs_top_assertions u_chk (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .capture_edge_in(capture_edge_in),
    .counter_run_out(counter_run_out), .channel_output_pin_out(channel_output_pin_out),
    .channel_match_interrupt_out(channel_match_interrupt_out)
);

/* testbench/tocs_top_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin failures++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end \
end
module tocs_top_tb_top;
    import tocs_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [15:0] cnt0 = 16'h0010;
    logic [15:0] cnt1 = 16'h0000;
    logic [1:0]  ovf = 2'b00;
    logic [5:0]  cap = 6'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  run;
    logic [3:0]  pins;
    logic [5:0]  ev;
    logic        irq;
    int          failures = 0;
    int          samples_checked = 0;

    always #25 clk = ~clk;

    tocs_top uut (.mclk_in(clk), .rst_n_in(rst_n), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .counter0_in(cnt0), .counter1_in(cnt1), .counter_ovf_in(ovf),
        .capture_edge_in(cap), .counter_run_out(run), .counter_clear_out(), .channel_output_pin_out(pins),
        .channel_match_interrupt_out(ev), .irq_out(irq));

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [1:0] s,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0000, d};
        pstrb <= {2'b00, s};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            failures++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, s, r, e);
    endtask : wr

    task automatic chkrd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 16'h0000, 2'b00, r, e);
        `CHK(nm, ex, r)
    endtask : chkrd

    // Bounded wait on a running flag; a flag that never rises ends the run
    task automatic wait_run(input int i);
        int n;
        n = 0;
        while (run[i] !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        if (run[i] !== 1'b1)
        begin
            failures++;
            report_and_stop();
        end
    endtask : wait_run

    task automatic settle(input int k);
        repeat (k) @(negedge clk);
    endtask : settle

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        chkrd(ADDR_OUTCTL, 32'h4444, "outctl_reset");
        chkrd(ADDR_TBSTAT, 32'h0, "tbstat_reset");
        `CHK("pins_reset", 4'h0, pins)
        apb(8'h60, 1'b0, 16'h0000, 2'b00, r, e);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, r)
        wr(ADDR_TBSTAT, 16'h00FF, 2'b11);
        chkrd(ADDR_TBSTAT, 32'h0, "tbstat_readonly");
    endtask : t_reset

    task automatic t_lanes();
        wr(ADDR_OUTCTL, 16'hFFFF, 2'b01);
        chkrd(ADDR_OUTCTL, 32'h44EE, "outctl_low_byte");
        wr(ADDR_OUTCTL, 16'h0000, 2'b10);
        chkrd(ADDR_OUTCTL, 32'h00EE, "outctl_high_byte");
        wr(ADDR_OUTCTL, 16'h0000, 2'b11);
        settle(2);
        `CHK("pins_active_low", 4'hF, pins)
        wr(ADDR_OUTCTL, 16'hFFFF, 2'b11);
        chkrd(ADDR_OUTCTL, 32'hEEEE, "outctl_unused");
        settle(2);
        `CHK("pins_stopped", 4'h0, pins)
    endtask : t_lanes

    task automatic t_run_timing();
        int n;
        wr(ADDR_MODE, 16'h8001, 2'b11);
        for (n = 1; n <= 10; n++)
        begin
            @(posedge clk);
            @(negedge clk);
            if (run[0] === 1'b1)
                break;
        end
        `CHK("start_clks", START_CLKS, n)
        chkrd(ADDR_TBSTAT, 32'h40, "tbstat_run0");
        wr(ADDR_MODE, 16'h8005, 2'b11);
        wait_run(1);
        chkrd(ADDR_TBSTAT, 32'hC0, "tbstat_run_both");
        wr(ADDR_MODE, 16'h0000, 2'b11);
        @(posedge clk);
        @(negedge clk);
        `CHK("stop_clks", 2'b00, run)
    endtask : t_run_timing

    task automatic t_compare();
        logic [15:0] cmpv [4] = '{16'h0020, 16'h0005, 16'h0010, 16'hFFFF};
        logic        seen;
        wr(ADDR_CHMODE, 16'h0000, 2'b11);
        for (int i = 1; i <= 4; i++)
            wr(8'(ADDR_CC0 + i * ADDR_CC_STEP), cmpv[i - 1], 2'b11);
        wr(ADDR_MODE, 16'h8001, 2'b11);
        wait_run(0);
        settle(2);
        `CHK("pins_pwm", 4'b1001, pins)
        @(posedge clk);
        cnt0 <= 16'h0020;
        seen = 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            seen = seen | (ev[1] === 1'b1);
        end
        `CHK("compare_event", 1'b1, seen)
        wr(ADDR_MODE, 16'h0000, 2'b11);
        repeat (8)
        begin
            chkrd(ADDR_TBSTAT, 32'h0, "run_flag_clear");
            if (failures == 0)
                break;
        end
        wr(ADDR_OUTCTL, 16'hAAAA, 2'b11);
        settle(2);
        `CHK("pins_low_active_stopped", 4'hF, pins)
    endtask : t_compare

    task automatic t_capture();
        logic [31:0] r;
        logic        e;
        int          n;
        wr(ADDR_OUTCTL, 16'h4444, 2'b11);
        wr(ADDR_CHMODE, 16'h2000, 2'b11);
        apb(ADDR_IRQSTAT, 1'b0, 16'h0000, 2'b00, r, e);
        wr(ADDR_IRQMASK, 16'h0004, 2'b01);
        wr(ADDR_MODE, 16'h8004, 2'b11);
        wait_run(1);
        @(posedge clk);
        cnt1 <= 16'h1234;
        ovf <= 2'b10;
        @(posedge clk);
        ovf <= 2'b00;
        cap <= 6'b100100;
        @(posedge clk);
        cap <= 6'h00;
        @(negedge clk);
        `CHK("capture_event", 6'b100100, ev)
        for (n = 0; n < 4 && irq !== 1'b1; n++)
            @(negedge clk);
        `CHK("irq_raised", 1'b1, irq)
        chkrd(ADDR_TBSTAT, 32'h80, "ovf_before_read");
        chkrd(8'h40, 32'h1234, "capture_value");
        chkrd(ADDR_TBSTAT, 32'h84, "ovf_after_read");
        chkrd(ADDR_IRQSTAT, 32'h24, "irq_status");
        settle(2);
        `CHK("irq_cleared", 1'b0, irq)
        wr(ADDR_IRQMASK, 16'h0000, 2'b01);
        @(posedge clk);
        cnt1 <= 16'h0042;
        cap <= 6'b000100;
        @(posedge clk);
        cap <= 6'h00;
        settle(4);
        `CHK("irq_masked", 1'b0, irq)
        chkrd(8'h40, 32'h0042, "capture_again");
        chkrd(ADDR_TBSTAT, 32'h80, "no_ovf_interval");
        chkrd(ADDR_IRQSTAT, 32'h04, "irq_status_masked");
    endtask : t_capture

    initial
    begin
        #1000000;
        failures++;
        report_and_stop();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_lanes();
        t_run_timing();
        t_compare();
        t_capture();
        report_and_stop();
    end
endmodule : tocs_top_tb_top
